/* hdl/lib_regs_pkg.sv */
// Constants for the legacy index base and system control register bank
package lib_regs_pkg;
    localparam logic [7:0] OFS_LEGACY_BASE = 8'h44;
    localparam logic [7:0] OFS_SYS_CTRL = 8'h80;
    localparam logic [31:0] RST_LEGACY_BASE = 32'h0000_0001;
    localparam logic [31:0] RST_SYS_CTRL = 32'h0044_9060;
    // Bits of the system control word that this bank drives itself
    localparam int BIT_SLOT_STEP_LO = 30;
    localparam int BIT_LINE_TIE = 29;
    localparam int BIT_RSVD_HI = 28;
    localparam int BIT_CLK_DIR = 27;
    localparam int BIT_IRQ_ROUTE = 26;
    localparam int BIT_IRQ_FLAG = 25;
    localparam int BIT_IRQ_ENABLE = 24;
    localparam int BIT_RSVD_LO = 23;
    localparam int BIT_SUBSYS_WE = 5;
    localparam logic [31:0] SYS_CTRL_OWN_MASK = 32'hff80_0020;
    localparam logic [1:0] RST_SLOT_STEP = 2'h0;
    localparam logic RST_LINE_TIE = 1'b0;
    localparam logic RST_CLK_DIR = 1'b0;
    localparam logic RST_IRQ_ROUTE = 1'b0;
    localparam logic RST_IRQ_ENABLE = 1'b0;
    localparam logic RST_SUBSYS_WE = 1'b1;
    localparam int SOCKETS = 2;
    localparam int SLOTS = 4;
endpackage

/* hdl/lib_regs.sv */
// Legacy index port base and upper system control register bank
//
// How it works
// - Index at base, data at base plus one
// - Base bits 31..1 writable, reset zero
// - Base bit 0 reads one always
// - One base register for both functions
// - Global control fields written via function 0 only
// - Slot step shifts serial interrupt slot pair
// - Tie merges both lines onto first line
// - Bits 28 and 23 read zero
// - Clock direction bit drives switch clock pin
// - Route bit picks IRQ2 or status change
// - Power write sets flag while enable is set; write one clears
// - Enable makes each power write interrupt
// - Subsystem ID writable only when bit 5 set
`timescale 1ns/1ps
module lib_regs (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic cfgValid,
    input wire logic cfgWrite,
    input wire logic cfgFunc,
    input wire logic [7:0] cfgAddr,
    input wire logic [3:0] cfgByteEn,
    input wire logic [31:0] cfgWdata,
    output logic [31:0] cfgRdata,
    output logic cfgAck,
    input wire logic [31:0] ioAddr,
    output logic ioIndexHit,
    output logic ioDataHit,
    output logic [31:0] indexPortAddr,
    output logic [31:0] dataPortAddr,
    input wire logic intLineA,
    input wire logic intLineB,
    output logic [lib_regs_pkg::SLOTS-1:0] serialSlotLevel,
    input wire logic [lib_regs_pkg::SOCKETS-1:0] powerWrite,
    output logic irq2Pulse,
    output logic [lib_regs_pkg::SOCKETS-1:0] cardStatusChangePulse,
    output logic [lib_regs_pkg::SOCKETS-1:0] powerWriteIrqFlag,
    input wire logic oscLevel,
    input wire logic switchClockIn,
    output logic switchClockOut,
    output logic switchClockOe,
    output logic switchClockSeen,
    output logic subsysIdWriteEnable
);
    import lib_regs_pkg::*;

    logic [31:1] baseAddr_reg;
    logic [1:0] irqSlotStep_reg;
    logic irqLineTie_reg;
    logic switchClockDir_reg;
    logic powerWriteIrqRoute_reg;
    logic powerWriteIrqEnable_reg;
    logic subsysIdWriteEnable_reg;
    logic [SOCKETS-1:0] flag_reg;
    logic [SOCKETS-1:0] flag_next;
    logic wrBase;
    logic wrCtrl;
    logic wrCtrlGlobal;
    logic [31:0] baseMerged;
    logic [31:0] ctrlWord;

    // Byte-lane merge of a write into a stored word
    function automatic logic [31:0] mergeBytes(input logic [31:0] oldVal,
            input logic [31:0] newVal, input logic [3:0] be);
        logic [31:0] res;
        res = oldVal;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[i*8 +: 8] = newVal[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // Slot that carries a line after stepping by the given amount
    function automatic logic [1:0] slotOf(input logic [1:0] line, input logic [1:0] step);
        return 2'(line + step);
    endfunction

    assign wrBase = cfgValid && cfgWrite && (cfgAddr == OFS_LEGACY_BASE);
    assign wrCtrl = cfgValid && cfgWrite && (cfgAddr == OFS_SYS_CTRL);
    assign wrCtrlGlobal = wrCtrl && !cfgFunc;
    assign baseMerged = mergeBytes({baseAddr_reg, 1'b0}, cfgWdata, cfgByteEn);

    // Either function reaches this single register
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            baseAddr_reg <= RST_LEGACY_BASE[31:1];
        end else if (wrBase) begin
            baseAddr_reg <= baseMerged[31:1];
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            irqSlotStep_reg <= RST_SLOT_STEP;
            irqLineTie_reg <= RST_LINE_TIE;
            switchClockDir_reg <= RST_CLK_DIR;
            powerWriteIrqRoute_reg <= RST_IRQ_ROUTE;
            powerWriteIrqEnable_reg <= RST_IRQ_ENABLE;
        end else if (wrCtrlGlobal && cfgByteEn[3]) begin
            irqSlotStep_reg <= cfgWdata[BIT_SLOT_STEP_LO +: 2];
            irqLineTie_reg <= cfgWdata[BIT_LINE_TIE];
            switchClockDir_reg <= cfgWdata[BIT_CLK_DIR];
            powerWriteIrqRoute_reg <= cfgWdata[BIT_IRQ_ROUTE];
            powerWriteIrqEnable_reg <= cfgWdata[BIT_IRQ_ENABLE];
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            subsysIdWriteEnable_reg <= RST_SUBSYS_WE;
        end else if (wrCtrlGlobal && cfgByteEn[0]) begin
            subsysIdWriteEnable_reg <= cfgWdata[BIT_SUBSYS_WE];
        end
    end

    // Each socket's flag belongs to its own function
    always_comb begin
        flag_next = flag_reg;
        for (int s = 0; s < SOCKETS; s++) begin
            if (wrCtrl && cfgByteEn[3] && (cfgFunc == s[0]) && cfgWdata[BIT_IRQ_FLAG]) begin
                flag_next[s] = 1'b0;
            end
            // Set is applied last so a racing event survives the clear
            if (powerWriteIrqEnable_reg && powerWrite[s]) begin
                flag_next[s] = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            flag_reg <= '0;
        end else begin
            flag_reg <= flag_next;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            irq2Pulse <= 1'b0;
            cardStatusChangePulse <= '0;
        end else begin
            irq2Pulse <= powerWriteIrqEnable_reg && !powerWriteIrqRoute_reg
                && (|powerWrite);
            cardStatusChangePulse <= (powerWriteIrqEnable_reg && powerWriteIrqRoute_reg)
                ? powerWrite : '0;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            serialSlotLevel <= '0;
        end else begin
            serialSlotLevel <= '0;
            if (irqLineTie_reg) begin
                serialSlotLevel[slotOf(2'h0, irqSlotStep_reg)] <= intLineA | intLineB;
            end else begin
                serialSlotLevel[slotOf(2'h0, irqSlotStep_reg)] <= intLineA;
                serialSlotLevel[slotOf(2'h1, irqSlotStep_reg)] <= intLineB;
            end
        end
    end

    // The pin only drives while the internal oscillator is selected
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            switchClockOut <= 1'b0;
            switchClockSeen <= 1'b0;
        end else begin
            switchClockOut <= switchClockDir_reg ? oscLevel : 1'b0;
            switchClockSeen <= switchClockDir_reg ? oscLevel : switchClockIn;
        end
    end
    assign switchClockOe = switchClockDir_reg;

    always_comb begin
        ctrlWord = RST_SYS_CTRL & ~SYS_CTRL_OWN_MASK;
        ctrlWord[BIT_SLOT_STEP_LO +: 2] = irqSlotStep_reg;
        ctrlWord[BIT_LINE_TIE] = irqLineTie_reg;
        ctrlWord[BIT_RSVD_HI] = 1'b0;
        ctrlWord[BIT_CLK_DIR] = switchClockDir_reg;
        ctrlWord[BIT_IRQ_ROUTE] = powerWriteIrqRoute_reg;
        ctrlWord[BIT_IRQ_FLAG] = flag_reg[cfgFunc];
        ctrlWord[BIT_IRQ_ENABLE] = powerWriteIrqEnable_reg;
        ctrlWord[BIT_RSVD_LO] = 1'b0;
        ctrlWord[BIT_SUBSYS_WE] = subsysIdWriteEnable_reg;
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            cfgAck <= 1'b0;
            cfgRdata <= '0;
        end else begin
            cfgAck <= cfgValid;
            if (cfgValid && !cfgWrite) begin
                if (cfgAddr == OFS_LEGACY_BASE) begin
                    cfgRdata <= {baseAddr_reg, 1'b1};
                end else if (cfgAddr == OFS_SYS_CTRL) begin
                    cfgRdata <= ctrlWord;
                end else begin
                    cfgRdata <= '0;
                end
            end
        end
    end

    assign indexPortAddr = {baseAddr_reg, 1'b0};
    assign dataPortAddr = {baseAddr_reg, 1'b1};
    assign ioIndexHit = (ioAddr == indexPortAddr);
    assign ioDataHit = (ioAddr == dataPortAddr);
    assign powerWriteIrqFlag = flag_reg;
    assign subsysIdWriteEnable = subsysIdWriteEnable_reg;

    sequence ctrlWriteF1Hi;
        wrCtrl && cfgFunc && cfgByteEn[3];
    endsequence
    sequence enabledPowerWrite0;
        powerWriteIrqEnable_reg && powerWrite[0];
    endsequence

    chk_base_pair: assert property (@(posedge clk_sys) disable iff (!arst_n)
        dataPortAddr == 32'(indexPortAddr + 32'h1))
        else $error("data port is not index plus one");
    chk_base_write: assert property (@(posedge clk_sys) disable iff (!arst_n)
        wrBase && (&cfgByteEn) |=> indexPortAddr[31:1] == $past(cfgWdata[31:1]))
        else $error("base address write not stored");
    chk_base_bit0: assert property (@(posedge clk_sys) disable iff (!arst_n)
        cfgValid && !cfgWrite && cfgAddr == OFS_LEGACY_BASE |=> cfgAck && cfgRdata[0])
        else $error("base bit 0 did not read one");
    chk_global_f1: assert property (@(posedge clk_sys) disable iff (!arst_n)
        ctrlWriteF1Hi |=> $stable(irqSlotStep_reg) && $stable(powerWriteIrqEnable_reg))
        else $error("function 1 changed a global field");
    chk_rsvd_zero: assert property (@(posedge clk_sys) disable iff (!arst_n)
        cfgValid && !cfgWrite && cfgAddr == OFS_SYS_CTRL |=> !cfgRdata[28] && !cfgRdata[23])
        else $error("reserved control bit read one");
    chk_tie_merge: assert property (@(posedge clk_sys) disable iff (!arst_n)
        irqLineTie_reg && intLineB && $stable(irqLineTie_reg) |=> serialSlotLevel[slotOf(2'h0,
        $past(irqSlotStep_reg))] && $countones(serialSlotLevel) == 1)
        else $error("tied lines not merged onto first slot");
    chk_step_slot: assert property (@(posedge clk_sys) disable iff (!arst_n)
        !irqLineTie_reg && intLineB && !intLineA |=>
        serialSlotLevel == 4'(4'h1 << slotOf(2'h1, $past(irqSlotStep_reg))))
        else $error("second line in wrong slot");
    chk_clk_dir: assert property (@(posedge clk_sys) disable iff (!arst_n)
        wrCtrlGlobal && cfgByteEn[3] |=> switchClockOe == $past(cfgWdata[27]))
        else $error("switch clock direction not applied");
    chk_flag_set: assert property (@(posedge clk_sys) disable iff (!arst_n)
        enabledPowerWrite0 |=> powerWriteIrqFlag[0])
        else $error("power write flag lost");
    chk_irq_route: assert property (@(posedge clk_sys) disable iff (!arst_n)
        enabledPowerWrite0 |=> (irq2Pulse != $past(powerWriteIrqRoute_reg))
        && (cardStatusChangePulse[0] == $past(powerWriteIrqRoute_reg)))
        else $error("power write interrupt misrouted");
    chk_no_irq_off: assert property (@(posedge clk_sys) disable iff (!arst_n)
        !powerWriteIrqEnable_reg |=> !irq2Pulse && cardStatusChangePulse == '0)
        else $error("interrupt while disabled");
endmodule

/* hdl/lib_regs_end.sv */
// Holds no logic; the whole register bank lives in the main design file

/* tb/lib_host_model.sv */
// Host configuration master model driving the bank's access port
`timescale 1ns/1ps
module lib_host_model (
    input wire logic clk_sys,
    output logic cfgValid,
    output logic cfgWrite,
    output logic cfgFunc,
    output logic [7:0] cfgAddr,
    output logic [3:0] cfgByteEn,
    output logic [31:0] cfgWdata,
    input wire logic [31:0] cfgRdata,
    input wire logic cfgAck
);
    logic ackOk;
    initial begin
        {cfgValid, cfgWrite, cfgFunc, cfgAddr, cfgByteEn, cfgWdata} = '0;
        ackOk = 1'b1;
    end
    // One-cycle request; address and data are scrambled once taken so stale values never help
    task automatic xfer(input logic w, input logic f, input logic [7:0] a,
        input logic [3:0] be, input logic [31:0] d, output logic [31:0] rq);
        @(posedge clk_sys);
        #1;
        {cfgValid, cfgWrite, cfgFunc, cfgAddr, cfgByteEn, cfgWdata} = {1'b1, w, f, a, be, d};
        @(posedge clk_sys);
        #1;
        cfgValid = 1'b0;
        cfgAddr = ~a;
        cfgWdata = ~d;
        rq = cfgRdata;
        ackOk = cfgAck;
    endtask
endmodule

/* tb/test_legacy_index_base_and_system_control.sv */
// Self-checking bench for the legacy base and system control bank
`timescale 1ns/1ps
module test_legacy_index_base_and_system_control;
    import lib_regs_pkg::*;
    typedef struct packed {logic wf; logic rf; logic [7:0] a; logic [3:0] be;
        logic [31:0] d; logic [31:0] e;} lib_row_t;
    logic clk_sys, arst_n, cfgValid, cfgWrite, cfgFunc, cfgAck, ioIndexHit, ioDataHit;
    logic intLineA, intLineB, irq2Pulse, oscLevel, switchClockIn, switchClockOut;
    logic switchClockOe, switchClockSeen, subsysIdWriteEnable;
    logic [7:0] cfgAddr;
    logic [3:0] cfgByteEn;
    logic [SLOTS-1:0] serialSlotLevel;
    logic [SOCKETS-1:0] powerWrite, cardStatusChangePulse, powerWriteIrqFlag;
    logic [31:0] cfgWdata, cfgRdata, ioAddr, indexPortAddr, dataPortAddr, q;
    int fails = 0;
    int checks = 0;
    lib_row_t rows [7] = '{
        {1'b0, 1'b0, 8'h44, 4'hf, 32'h1234_5679, 32'h1234_5679},
        {1'b1, 1'b0, 8'h44, 4'hf, 32'hffff_fffe, 32'hffff_ffff},
        {1'b0, 1'b1, 8'h44, 4'h1, 32'h0000_0000, 32'hffff_ff01},
        {1'b0, 1'b0, 8'h80, 4'h8, 32'hffff_ffff, 32'hed44_9060},
        {1'b1, 1'b1, 8'h80, 4'hf, 32'h0000_0000, 32'hed44_9060},
        {1'b0, 1'b0, 8'h80, 4'h1, 32'h0000_0000, 32'hed44_9040},
        {1'b0, 1'b0, 8'h48, 4'hf, 32'hffff_ffff, 32'h0000_0000}};
    lib_regs lib_regs_i (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .cfgValid(cfgValid),
        .cfgWrite(cfgWrite),
        .cfgFunc(cfgFunc),
        .cfgAddr(cfgAddr),
        .cfgByteEn(cfgByteEn),
        .cfgWdata(cfgWdata),
        .cfgRdata(cfgRdata),
        .cfgAck(cfgAck),
        .ioAddr(ioAddr),
        .ioIndexHit(ioIndexHit),
        .ioDataHit(ioDataHit),
        .indexPortAddr(indexPortAddr),
        .dataPortAddr(dataPortAddr),
        .intLineA(intLineA),
        .intLineB(intLineB),
        .serialSlotLevel(serialSlotLevel),
        .powerWrite(powerWrite),
        .irq2Pulse(irq2Pulse),
        .cardStatusChangePulse(cardStatusChangePulse),
        .powerWriteIrqFlag(powerWriteIrqFlag),
        .oscLevel(oscLevel),
        .switchClockIn(switchClockIn),
        .switchClockOut(switchClockOut),
        .switchClockOe(switchClockOe),
        .switchClockSeen(switchClockSeen),
        .subsysIdWriteEnable(subsysIdWriteEnable)
    );
    lib_host_model lib_host_model_i (
        .clk_sys(clk_sys),
        .cfgValid(cfgValid),
        .cfgWrite(cfgWrite),
        .cfgFunc(cfgFunc),
        .cfgAddr(cfgAddr),
        .cfgByteEn(cfgByteEn),
        .cfgWdata(cfgWdata),
        .cfgRdata(cfgRdata),
        .cfgAck(cfgAck)
    );
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    task automatic end_sim;
        if (fails == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            fails++;
            $display("BAD %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic f, input logic [7:0] a, input logic [3:0] be,
        input logic [31:0] d);
        lib_host_model_i.xfer(1'b1, f, a, be, d, q);
        chk(lib_host_model_i.ackOk, 1'b1);
    endtask
    task automatic rd(input logic f, input logic [7:0] a, input logic [31:0] e);
        lib_host_model_i.xfer(1'b0, f, a, 4'h0, 32'h0, q);
        chk(lib_host_model_i.ackOk, 1'b1);
        chk(q, e);
    endtask
    // Power write strobe lands on the same edge as a request started together with it
    task automatic pw(input logic [1:0] s);
        @(posedge clk_sys);
        #1 powerWrite = s;
        @(posedge clk_sys);
        #1 powerWrite = 2'b00;
    endtask
    initial begin
        #100000;
        fails++;
        end_sim();
    end
    initial begin
        {arst_n, intLineA, intLineB, powerWrite, switchClockIn} = '0;
        ioAddr = 32'h0;
        oscLevel = 1'b1;
        repeat (20) @(posedge clk_sys);
        #1 arst_n = 1'b1;
        foreach (rows[i]) begin
            wr(rows[i].wf, rows[i].a, rows[i].be, rows[i].d);
            rd(rows[i].rf, rows[i].a, rows[i].e);
        end
        chk(indexPortAddr, 32'hffff_ff00);
        chk(dataPortAddr, 32'hffff_ff01);
        ioAddr = 32'hffff_ff01;
        #1 chk({ioIndexHit, ioDataHit}, 2'b01);
        @(posedge clk_sys);
        #1 ioAddr = 32'hffff_ff00;
        #1 chk({ioIndexHit, ioDataHit}, 2'b10);
        chk(subsysIdWriteEnable, 1'b0);
        chk({switchClockOe, switchClockOut, switchClockSeen}, 3'b111);
        @(posedge clk_sys);
        #1 oscLevel = 1'b0;
        @(posedge clk_sys);
        #1 chk({switchClockOe, switchClockOut, switchClockSeen}, 3'b100);
        oscLevel = 1'b1;
        pw(2'b10);
        chk({irq2Pulse, cardStatusChangePulse, powerWriteIrqFlag}, 5'b01010);
        wr(1'b1, 8'h80, 4'h8, 32'h0200_0000);
        chk(powerWriteIrqFlag, 2'b00);
        wr(1'b0, 8'h80, 4'h8, 32'h0100_0000);
        pw(2'b01);
        chk({irq2Pulse, cardStatusChangePulse, powerWriteIrqFlag}, 5'b10001);
        @(posedge clk_sys);
        #1 chk(irq2Pulse, 1'b0);
        fork
            wr(1'b0, 8'h80, 4'h8, 32'h0300_0000);
            pw(2'b01);
        join
        chk(powerWriteIrqFlag, 2'b01);
        wr(1'b0, 8'h80, 4'h8, 32'h0000_0000);
        chk(powerWriteIrqFlag, 2'b01);
        wr(1'b0, 8'h80, 4'h8, 32'h0200_0000);
        pw(2'b11);
        chk({irq2Pulse, cardStatusChangePulse, powerWriteIrqFlag}, 5'b00000);
        switchClockIn = 1'b1;
        @(posedge clk_sys);
        #1 chk({switchClockOe, switchClockOut, switchClockSeen}, 3'b001);
        for (int k = 0; k < 8; k++) begin
            wr(1'b0, 8'h80, 4'h8, {k[1:0], k[2], 29'h0});
            {intLineA, intLineB} = 2'b10;
            @(posedge clk_sys);
            #1 chk(serialSlotLevel, 4'h1 << k[1:0]);
            {intLineA, intLineB} = 2'b01;
            @(posedge clk_sys);
            #1 chk(serialSlotLevel, 4'h1 << (k[2] ? k[1:0] : k[1:0] + 2'h1));
        end
        @(posedge clk_sys);
        #1 arst_n = 1'b0;
        #1 chk(indexPortAddr, 32'h0);
        chk(dataPortAddr, 32'h1);
        chk({subsysIdWriteEnable, switchClockOe, powerWriteIrqFlag}, 4'b1000);
        @(posedge clk_sys);
        #1 arst_n = 1'b1;
        rd(1'b1, 8'h44, 32'h0000_0001);
        rd(1'b0, 8'h80, 32'h0044_9060);
        end_sim();
    end
endmodule
